// ---- core/usbfs_defines.svh ----
// Constants for the full-speed port control block.
// Assumes inclusion by bare name from the core/ files.
`ifndef USBFS_DEFINES_SVH
`define USBFS_DEFINES_SVH
// ----------------------------------------------------------------
// Identity and endpoint layout
// ----------------------------------------------------------------
`define USBFS_PERIPH_ID 6'h23
`define USBFS_DUAL_BANK_MASK 8'hf6
`define USBFS_EP_ZERO 3'h0
// ----------------------------------------------------------------
// Packet identifiers and setup packet layout
// ----------------------------------------------------------------
`define USBFS_PID_ACK 4'h2
`define USBFS_PID_NAK 4'ha
`define USBFS_PID_STALL 4'he
`define USBFS_PID_DATA0 4'h3
`define USBFS_PID_DATA1 4'hb
`define USBFS_SETUP_LAST 3'h7
`define USBFS_LEN_LO_IDX 3'h6
`define USBFS_DIR_BIT 7
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define USBFS_CLK_MHZ 100
`define USBFS_BUS_CLK_TIMEOUT_NS 100
`define USBFS_BUS_CLK_TIMEOUT_CYC ((`USBFS_BUS_CLK_TIMEOUT_NS * `USBFS_CLK_MHZ) / 1000)
`endif

// ---- core/usbfs_pkg.sv ----
// Types shared by the port control block.
// Assumes usbfs_defines.svh is compiled alongside.
package usbfs_pkg;
	// ----------------------------------------------------------------
	// Token kinds and control stages
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} usbfs_tok_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP_RX, ST_DATA_IN, ST_DATA_OUT, ST_STATUS_IN, ST_STATUS_OUT
	} usbfs_stage_t;
endpackage : usbfs_pkg

// ---- core/usbfs_sync.sv ----
// Three-stage synchroniser for asynchronous pin inputs.
// Assumes one destination clock; output moves once stages two and three agree.
`timescale 1ns/10ps
module usbfs_sync #(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] s1, s2, s3;
	logic [WIDTH-1:0] next_q;
	// ----------------------------------------------------------------
	// Agreement filter, per bit
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_comb begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q_o[i];
		end
	end
	// First stage feeds only the second
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q_o <= '0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end
endmodule : usbfs_sync

// ---- core/usbfs_skid.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; all outputs come from flip-flops.
`timescale 1ns/10ps
module usbfs_skid (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic s_valid_i,
	input wire logic [7:0] s_data_i,
	output logic s_ready_o,
	output logic m_valid_o,
	output logic [7:0] m_data_o,
	input wire logic m_ready_i
);
	logic [7:0] tail, next_head, next_tail;
	logic next_hv, next_tv;
	logic push, pop;
	// ----------------------------------------------------------------
	// Ready falls only when both entries hold data
	// ----------------------------------------------------------------
	always_comb begin
		push = s_valid_i & s_ready_o;
		pop = m_valid_o & m_ready_i;
		next_head = m_data_o;
		next_tail = tail;
		next_hv = m_valid_o;
		next_tv = ~s_ready_o;
		if (pop && !s_ready_o) begin
			next_head = tail;
			next_tv = 1'b0;
		end else if (pop) begin
			next_head = s_data_i;
			next_hv = push;
		end else if (push && !m_valid_o) begin
			next_head = s_data_i;
			next_hv = 1'b1;
		end else if (push) begin
			next_tail = s_data_i;
			next_tv = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			m_data_o <= 8'h00;
			tail <= 8'h00;
			m_valid_o <= 1'b0;
			s_ready_o <= 1'b1;
		end else begin
			m_data_o <= next_head;
			tail <= next_tail;
			m_valid_o <= next_hv;
			s_ready_o <= ~next_tv;
		end
	end
endmodule : usbfs_skid

// ---- core/usbfs_port_ctrl.sv ----
// Full-speed device port: pin ownership, pull control, control-transfer stages.
// Assumes tokens come from a same-clock serial engine; pins are asynchronous.
// ----------------------------------------------------------------
// Summary of operation
// - Pins serve the bus after reset; pin-select input hands them to GPIO.
// - Register side on sys clock; 48 MHz bus clock is watched for activity.
// - One interrupt line out; peripheral identifier 35 is reported.
// - In bus mode, transceiver disable turns pull-downs on; pull-up follows its enable bit.
// - Control traffic only on single-bank endpoints; else stalled.
// - Isochronous traffic only on dual-bank endpoints; else dropped.
// - Three token kinds: setup, data in, data out.
// - Status stage closes a control transfer, direction opposite data.
// - Status in answers a zero-length DATA1 packet.
// - Stall request aborts a running control transfer.
// - Endpoint zero is always a control endpoint.
// - Setup auto-acknowledged; flag held until cleared; interrupt while flag and enable are set.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "usbfs_defines.svh"
module usbfs_port_ctrl (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic usb_bus_clock_48m_i,
	input wire logic system_io_pin_select_i,
	input wire logic transceiver_disable_i,
	input wire logic dplus_pullup_on_i,
	input wire logic usb_plus_line_i,
	input wire logic usb_minus_line_i,
	output logic usb_plus_line_o,
	output logic usb_minus_line_o,
	output logic usb_plus_line_oe_o,
	output logic usb_minus_line_oe_o,
	output logic pulldown_en_o,
	output logic pullup_en_o,
	input wire logic usb_tx_plus_i,
	input wire logic usb_tx_minus_i,
	input wire logic usb_tx_oe_i,
	output logic usb_rx_plus_o,
	output logic usb_rx_minus_o,
	input wire logic gpio_plus_out_i,
	input wire logic gpio_minus_out_i,
	input wire logic gpio_oe_i,
	output logic gpio_plus_in_o,
	output logic gpio_minus_in_o,
	output logic bus_clk_ok_o,
	input wire logic token_valid_i,
	input wire usbfs_pkg::usbfs_tok_t token_kind_i,
	input wire logic [2:0] token_ep_i,
	input wire logic token_iso_i,
	input wire logic token_zlp_i,
	input wire logic [2:0] ctrl_ep_i,
	input wire logic in_ready_i,
	input wire logic stall_req_i,
	output logic hs_valid_o,
	output logic [3:0] hs_pid_o,
	output logic hs_zlp_o,
	output logic iso_error_o,
	output usbfs_pkg::usbfs_stage_t ctrl_stage_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	output logic fifo_valid_o,
	output logic [7:0] fifo_data_o,
	input wire logic fifo_ready_i,
	output logic setup_received_flag_o,
	input wire logic setup_flag_clr_i,
	input wire logic irq_enable_i,
	output logic irq_o,
	output logic [5:0] periph_id_o
);
	import usbfs_pkg::*;

	// ----------------------------------------------------------------
	// Endpoint decoding
	// ----------------------------------------------------------------
	function automatic logic is_dual(input logic [2:0] ep);
		logic [7:0] mask;
		mask = `USBFS_DUAL_BANK_MASK;
		is_dual = mask[ep];
	endfunction : is_dual

	// Endpoint zero is always control; so is the ctrl_ep_i endpoint, even when dual-bank
	function automatic logic is_ctrl(input logic [2:0] ep, input logic [2:0] cep);
		is_ctrl = (ep == `USBFS_EP_ZERO) || (ep == cep);
	endfunction : is_ctrl

	logic [2:0] pin_sync;
	logic ctrl_hit, setup_tok, in_tok, out_tok, rx_push;
	logic clk_prev, clk_edge;
	logic [7:0] clk_idle, next_clk_idle;
	logic next_clk_ok, next_clk_prev;
	logic next_dp, next_dm, next_dp_oe, next_dm_oe, next_pd, next_pu;
	logic next_hs_valid, next_hs_zlp, next_iso_err, next_flag, next_irq;
	logic [3:0] next_pid;
	logic [2:0] byte_idx, next_byte_idx;
	logic dir_in, next_dir_in, len_zero, next_len_zero, toggle, next_toggle;
	usbfs_stage_t next_stage;

	// ----------------------------------------------------------------
	// Pin and clock synchronisers
	// ----------------------------------------------------------------
	// Bus clock sampled as a level; edges faster than half our rate may merge
	usbfs_sync #(.WIDTH(3)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i({usb_bus_clock_48m_i, usb_minus_line_i, usb_plus_line_i}),
		.q_o(pin_sync)
	);

	// Setup and data bytes pass a two-entry buffer toward software
	usbfs_skid u_skid (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.s_valid_i(rx_valid_i),
		.s_data_i(rx_data_i),
		.s_ready_o(rx_ready_o),
		.m_valid_o(fifo_valid_o),
		.m_data_o(fifo_data_o),
		.m_ready_i(fifo_ready_i)
	);

	// ----------------------------------------------------------------
	// Pin ownership and pull control
	// ----------------------------------------------------------------
	// Pulls are released in GPIO mode so they never fight a port driver
	always_comb begin
		next_dp = system_io_pin_select_i ? gpio_plus_out_i : usb_tx_plus_i;
		next_dm = system_io_pin_select_i ? gpio_minus_out_i : usb_tx_minus_i;
		next_dp_oe = system_io_pin_select_i ? gpio_oe_i
			: (usb_tx_oe_i & ~transceiver_disable_i);
		next_dm_oe = next_dp_oe;
		next_pd = transceiver_disable_i & ~system_io_pin_select_i;
		next_pu = dplus_pullup_on_i & ~system_io_pin_select_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			usb_plus_line_o <= 1'b0;
			usb_minus_line_o <= 1'b0;
			usb_plus_line_oe_o <= 1'b0;
			usb_minus_line_oe_o <= 1'b0;
			pulldown_en_o <= 1'b0;
			pullup_en_o <= 1'b0;
			usb_rx_plus_o <= 1'b0;
			usb_rx_minus_o <= 1'b0;
			gpio_plus_in_o <= 1'b0;
			gpio_minus_in_o <= 1'b0;
			periph_id_o <= `USBFS_PERIPH_ID;
		end else begin
			usb_plus_line_o <= next_dp;
			usb_minus_line_o <= next_dm;
			usb_plus_line_oe_o <= next_dp_oe;
			usb_minus_line_oe_o <= next_dm_oe;
			pulldown_en_o <= next_pd;
			pullup_en_o <= next_pu;
			usb_rx_plus_o <= pin_sync[0] & ~system_io_pin_select_i;
			usb_rx_minus_o <= pin_sync[1] & ~system_io_pin_select_i;
			gpio_plus_in_o <= pin_sync[0] & system_io_pin_select_i;
			gpio_minus_in_o <= pin_sync[1] & system_io_pin_select_i;
			periph_id_o <= `USBFS_PERIPH_ID;
		end
	end

	// ----------------------------------------------------------------
	// Bus clock activity monitor
	// ----------------------------------------------------------------
	// Any edge of the synchronised 48 MHz clock restarts the quiet counter
	always_comb begin
		next_clk_prev = pin_sync[2];
		clk_edge = pin_sync[2] ^ clk_prev;
		next_clk_idle = clk_edge ? 8'h00 : clk_idle;
		if (!clk_edge && clk_idle != 8'(`USBFS_BUS_CLK_TIMEOUT_CYC)) begin
			next_clk_idle = clk_idle + 8'h01;
		end
		next_clk_ok = (next_clk_idle != 8'(`USBFS_BUS_CLK_TIMEOUT_CYC));
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_prev <= 1'b0;
			clk_idle <= 8'h00;
			bus_clk_ok_o <= 1'b0;
		end else begin
			clk_prev <= next_clk_prev;
			clk_idle <= next_clk_idle;
			bus_clk_ok_o <= next_clk_ok;
		end
	end

	// ----------------------------------------------------------------
	// Control-transfer stage machine and handshake answer
	// ----------------------------------------------------------------
	// Only tokens for the control endpoint are answered here
	always_comb begin
		ctrl_hit = token_valid_i && is_ctrl(token_ep_i, ctrl_ep_i) && !token_iso_i;
		setup_tok = ctrl_hit && (token_kind_i == TOK_SETUP);
		in_tok = ctrl_hit && (token_kind_i == TOK_IN);
		out_tok = ctrl_hit && (token_kind_i == TOK_OUT);
		rx_push = rx_valid_i & rx_ready_o;
		next_stage = ctrl_stage_o;
		next_hs_valid = 1'b0;
		next_hs_zlp = 1'b0;
		next_pid = `USBFS_PID_NAK;
		next_iso_err = token_valid_i && token_iso_i && !is_dual(token_ep_i);
		next_byte_idx = byte_idx;
		next_dir_in = dir_in;
		next_len_zero = len_zero;
		next_toggle = toggle;
		if (ctrl_hit && is_dual(token_ep_i) && token_ep_i != `USBFS_EP_ZERO) begin
			next_hs_valid = 1'b1;
			next_pid = `USBFS_PID_STALL;
			next_stage = ST_IDLE;
		end else if (setup_tok) begin
			next_hs_valid = 1'b1;
			next_pid = `USBFS_PID_ACK;
			next_stage = ST_SETUP_RX;
			next_byte_idx = 3'h0;
			next_len_zero = 1'b1;
			next_toggle = 1'b1;
		end else if ((in_tok || out_tok) && stall_req_i && ctrl_stage_o != ST_IDLE) begin
			next_hs_valid = 1'b1;
			next_pid = `USBFS_PID_STALL;
			next_stage = ST_IDLE;
		end else begin
			unique case (ctrl_stage_o)
				ST_IDLE: begin
				end
				ST_SETUP_RX: begin
					if (rx_push) begin
						next_byte_idx = byte_idx + 3'h1;
						if (byte_idx == 3'h0) begin
							next_dir_in = rx_data_i[`USBFS_DIR_BIT];
						end
						if (byte_idx >= `USBFS_LEN_LO_IDX && rx_data_i != 8'h00) begin
							next_len_zero = 1'b0;
						end
						if (byte_idx == `USBFS_SETUP_LAST) begin
							if (next_len_zero) begin
								next_stage = ST_STATUS_IN;
							end else if (dir_in) begin
								next_stage = ST_DATA_IN;
							end else begin
								next_stage = ST_DATA_OUT;
							end
						end
					end
				end
				ST_DATA_IN: begin
					if (in_tok) begin
						next_hs_valid = 1'b1;
						if (in_ready_i) begin
							next_pid = toggle ? `USBFS_PID_DATA1 : `USBFS_PID_DATA0;
							next_toggle = ~toggle;
						end
					end else if (out_tok) begin
						next_stage = ST_STATUS_OUT;
					end
				end
				ST_DATA_OUT: begin
					if (out_tok) begin
						// Setup bytes still unread must not be overwritten
						next_hs_valid = 1'b1;
						next_pid = setup_received_flag_o ? `USBFS_PID_NAK : `USBFS_PID_ACK;
					end else if (in_tok) begin
						next_hs_valid = 1'b1;
						next_pid = `USBFS_PID_DATA1;
						next_hs_zlp = 1'b1;
						next_stage = ST_IDLE;
					end
				end
				ST_STATUS_IN: begin
					if (in_tok) begin
						next_hs_valid = 1'b1;
						next_pid = `USBFS_PID_DATA1;
						next_hs_zlp = 1'b1;
						next_stage = ST_IDLE;
					end
				end
				ST_STATUS_OUT: begin
					// Only an OUT token closes the status stage
					if (out_tok) begin
						next_hs_valid = 1'b1;
						next_pid = token_zlp_i ? `USBFS_PID_ACK : `USBFS_PID_STALL;
						next_stage = ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_stage_o <= ST_IDLE;
			hs_valid_o <= 1'b0;
			hs_pid_o <= `USBFS_PID_NAK;
			hs_zlp_o <= 1'b0;
			iso_error_o <= 1'b0;
			byte_idx <= 3'h0;
			dir_in <= 1'b0;
			len_zero <= 1'b1;
			toggle <= 1'b0;
		end else begin
			ctrl_stage_o <= next_stage;
			hs_valid_o <= next_hs_valid;
			hs_pid_o <= next_pid;
			hs_zlp_o <= next_hs_zlp;
			iso_error_o <= next_iso_err;
			byte_idx <= next_byte_idx;
			dir_in <= next_dir_in;
			len_zero <= next_len_zero;
			toggle <= next_toggle;
		end
	end

	// ----------------------------------------------------------------
	// Setup flag and interrupt line
	// ----------------------------------------------------------------
	// A setup arriving with the clear keeps the flag set
	always_comb begin
		next_flag = (setup_received_flag_o & ~setup_flag_clr_i) | setup_tok;
		next_irq = next_flag & irq_enable_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			setup_received_flag_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			setup_received_flag_o <= next_flag;
			irq_o <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	property p_pins_usb;
		!system_io_pin_select_i |=> usb_plus_line_oe_o == $past(usb_tx_oe_i & ~transceiver_disable_i);
	endproperty
	a_pins_usb: assert property (p_pins_usb) else $error("pin owner wrong");

	property p_pulldown;
		transceiver_disable_i && !system_io_pin_select_i |=> pulldown_en_o;
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("pulldown off");

	property p_pullup;
		!dplus_pullup_on_i |=> !pullup_en_o;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup stuck");

	property p_setup_ack;
		setup_tok && !is_dual(token_ep_i) |=> hs_valid_o && hs_pid_o == `USBFS_PID_ACK
			&& setup_received_flag_o && ctrl_stage_o == ST_SETUP_RX;
	endproperty
	a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");

	property p_flag_hold;
		setup_received_flag_o && !setup_flag_clr_i |=> setup_received_flag_o;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

	property p_irq;
		irq_o == (setup_received_flag_o && $past(irq_enable_i));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_status_in;
		ctrl_stage_o == ST_STATUS_IN && in_tok && !stall_req_i
			|=> hs_pid_o == `USBFS_PID_DATA1 && hs_zlp_o ##1 !hs_zlp_o;
	endproperty
	a_status_in: assert property (p_status_in) else $error("status in not zlp");

	property p_stall;
		(in_tok || out_tok) && stall_req_i && ctrl_stage_o != ST_IDLE
			|=> hs_pid_o == `USBFS_PID_STALL && ctrl_stage_o == ST_IDLE;
	endproperty
	a_stall: assert property (p_stall) else $error("stall missed");

	property p_iso;
		token_valid_i && token_iso_i && !is_dual(token_ep_i) |=> iso_error_o && !hs_valid_o;
	endproperty
	a_iso: assert property (p_iso) else $error("iso on single bank");

	property p_id;
		##1 periph_id_o == `USBFS_PERIPH_ID;
	endproperty
	a_id: assert property (p_id) else $error("id wrong");

	c_status_in: cover property (ctrl_stage_o == ST_STATUS_IN ##[1:50] ctrl_stage_o == ST_IDLE);
	c_data_out: cover property (ctrl_stage_o == ST_DATA_OUT ##[1:50] hs_zlp_o);
	c_stall: cover property (hs_valid_o && hs_pid_o == `USBFS_PID_STALL);
endmodule : usbfs_port_ctrl

// ---- tb/usbfs_host_model.sv ----
// Host-side partner model: issues tokens and streams setup bytes into the port.
// Assumes its tasks are called at falling-edge time of the shared system clock.
`timescale 1ns/10ps
module usbfs_host_model (
	input wire logic sys_clk_i,
	input wire logic rx_ready_i,
	input wire logic hs_valid_i,
	input wire logic [3:0] hs_pid_i,
	input wire logic hs_zlp_i,
	input wire logic iso_error_i,
	output logic token_valid_o,
	output usbfs_pkg::usbfs_tok_t token_kind_o,
	output logic [2:0] token_ep_o,
	output logic token_iso_o,
	output logic token_zlp_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic dp_o,
	output logic dm_o
);
	import usbfs_pkg::*;
	// Idle J state on the pair whenever the port is not driving it
	assign dp_o = 1'b1;
	assign dm_o = 1'b0;
	// Quiet strobes at time zero
	initial begin
		{token_valid_o, token_ep_o, token_iso_o, token_zlp_o, rx_valid_o, rx_data_o} = '0;
		token_kind_o = TOK_SETUP;
	end
	// ----------------------------------------------------------------
	// Token issue
	// ----------------------------------------------------------------
	// One-cycle strobe; answer gathered over the next two falling edges
	task automatic send_token(input usbfs_tok_t kind, input logic [2:0] ep, input logic iso,
		input logic zlp, output logic v, output logic z, output logic e, output logic [3:0] p);
		@(negedge sys_clk_i);
		token_valid_o = 1'b1;
		token_kind_o = kind;
		token_ep_o = ep;
		token_iso_o = iso;
		token_zlp_o = zlp;
		@(negedge sys_clk_i);
		token_valid_o = 1'b0;
		// Scramble released fields
		token_kind_o = usbfs_tok_t'(~kind);
		{token_ep_o, token_iso_o, token_zlp_o} = ~{ep, iso, zlp};
		{v, z, e, p} = '0;
		repeat (2) begin
			if (hs_valid_i === 1'b1) begin
				{v, z, p} = {1'b1, hs_zlp_i, hs_pid_i};
			end
			if (iso_error_i === 1'b1) begin
				e = 1'b1;
			end
			@(negedge sys_clk_i);
		end
	endtask : send_token
	// ----------------------------------------------------------------
	// Setup payload
	// ----------------------------------------------------------------
	// Byte held until ready; bounded wait
	task automatic send_setup(input logic [63:0] pkt, output logic ok);
		int n;
		ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rx_valid_o = 1'b1;
			rx_data_o = pkt[8*i +: 8];
			n = 0;
			while (rx_ready_i !== 1'b1 && n < 200) begin
				@(negedge sys_clk_i);
				n++;
			end
			if (n == 200) begin
				ok = 1'b0;
			end
			@(negedge sys_clk_i);
		end
		rx_valid_o = 1'b0;
		rx_data_o = ~rx_data_o;
	endtask : send_setup
endmodule : usbfs_host_model

// ---- tb/usbfs_port_ctrl_bench.sv ----
// Self-checking bench for the full-speed port control block.
// Assumes the core files and the host model are compiled before it.
`timescale 1ns/10ps
`include "usbfs_defines.svh"
module usbfs_port_ctrl_bench;
	import usbfs_pkg::*;
	localparam logic [7:0] ACKED = {4'h2, `USBFS_PID_ACK};
	localparam logic [7:0] NAKED = {4'h2, `USBFS_PID_NAK};
	localparam logic [7:0] STALLED = {4'h2, `USBFS_PID_STALL};
	localparam logic [7:0] D0 = {4'h2, `USBFS_PID_DATA0};
	localparam logic [7:0] D1 = {4'h2, `USBFS_PID_DATA1};
	localparam logic [7:0] ZLP1 = {4'h3, `USBFS_PID_DATA1};
	localparam logic [7:0] ISOERR = 8'h40;
	localparam logic [63:0] BUFPKT = 64'h0000_0708_0506_0403;
	logic sys_clk_i, rst_i, usb_bus_clock_48m_i, bclk_run, system_io_pin_select_i;
	logic transceiver_disable_i, dplus_pullup_on_i, usb_plus_line_i, usb_minus_line_i;
	logic usb_plus_line_o, usb_minus_line_o, usb_plus_line_oe_o, usb_minus_line_oe_o;
	logic pulldown_en_o, pullup_en_o, usb_tx_plus_i, usb_tx_minus_i, usb_tx_oe_i, usb_rx_plus_o;
	logic usb_rx_minus_o, gpio_plus_out_i, gpio_minus_out_i, gpio_oe_i, gpio_plus_in_o;
	logic gpio_minus_in_o, bus_clk_ok_o, token_valid_i, token_iso_i, token_zlp_i, in_ready_i;
	logic stall_req_i, hs_valid_o, hs_zlp_o, iso_error_o, rx_valid_i, rx_ready_o, fifo_valid_o;
	logic fifo_ready_i, setup_received_flag_o, setup_flag_clr_i, irq_enable_i, irq_o;
	logic host_dp, host_dm, ok;
	logic [2:0] token_ep_i, ctrl_ep_i;
	logic [3:0] hs_pid_o;
	logic [5:0] periph_id_o;
	logic [7:0] rx_data_i, fifo_data_o, pins_seen;
	usbfs_tok_t token_kind_i;
	usbfs_stage_t ctrl_stage_o;
	int num_errors, samples_checked;
	logic [7:0] rxq[$];
	// Pin rows: {sel, txdis, dplus_pullup_on, tx_p, tx_m, tx_oe, gp_p, gp_oe} then
	// {oe_p, out_p, out_m, pulldown, pullup, rx_p, gpio_in_p, oe_m}
	logic [15:0] rows [5] = '{16'h2ca9, 16'h5454, 16'h85a1, 16'h8242, 16'h200c};
	// Port drives the wire when enabled, else host idle
	assign usb_plus_line_i = usb_plus_line_oe_o ? usb_plus_line_o : host_dp;
	assign usb_minus_line_i = usb_minus_line_oe_o ? usb_minus_line_o : host_dm;
	assign pins_seen = {usb_plus_line_oe_o, usb_plus_line_o, usb_minus_line_o, pulldown_en_o,
		pullup_en_o, usb_rx_plus_o, gpio_plus_in_o, usb_minus_line_oe_o};
	usbfs_port_ctrl dut (.*);
	usbfs_host_model host (
		.sys_clk_i(sys_clk_i), .rx_ready_i(rx_ready_o), .hs_valid_i(hs_valid_o),
		.hs_pid_i(hs_pid_o), .hs_zlp_i(hs_zlp_o), .iso_error_i(iso_error_o),
		.token_valid_o(token_valid_i), .token_kind_o(token_kind_i), .token_ep_o(token_ep_i),
		.token_iso_o(token_iso_i), .token_zlp_o(token_zlp_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .dp_o(host_dp), .dm_o(host_dm)
	);
	// ----------------------------------------------------------------
	// Clocks and receiver monitor
	// ----------------------------------------------------------------
	// System clock, 10 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// Slow bus clock so the filter sees every edge
	initial begin
		usb_bus_clock_48m_i = 1'b0;
		forever #20 usb_bus_clock_48m_i = bclk_run ? ~usb_bus_clock_48m_i : usb_bus_clock_48m_i;
	end
	// Every word the receiver takes, in order
	always @(posedge sys_clk_i) begin
		if (fifo_valid_o === 1'b1 && fifo_ready_i === 1'b1) begin
			rxq.push_back(fifo_data_o);
		end
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	// Answer as {0, iso_err, valid, zlp, pid}
	task automatic tok(input usbfs_tok_t k, input logic [2:0] ep, input logic iso,
		input logic zlp, input logic [7:0] exp);
		logic v, z, e;
		logic [3:0] p;
		host.send_token(k, ep, iso, zlp, v, z, e, p);
		check({1'b0, e, v, z, v ? p : 4'h0}, exp);
	endtask : tok
	task automatic stage_is(input usbfs_stage_t st);
		check(8'(ctrl_stage_o), 8'(st));
	endtask : stage_is
	task automatic setup_xfer(input logic [63:0] pkt, input usbfs_stage_t st);
		logic good;
		tok(TOK_SETUP, 3'h0, 1'b0, 1'b0, ACKED);
		host.send_setup(pkt, good);
		check(8'(good), 8'h01);
		if (good !== 1'b1) complete_run();
		repeat (2) @(negedge sys_clk_i);
		stage_is(st);
	endtask : setup_xfer
	task automatic clr_flag;
		setup_flag_clr_i = 1'b1;
		@(negedge sys_clk_i);
		setup_flag_clr_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
	endtask : clr_flag
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_i, bclk_run, system_io_pin_select_i, transceiver_disable_i, usb_tx_plus_i,
			usb_tx_minus_i, usb_tx_oe_i, gpio_plus_out_i, gpio_minus_out_i, gpio_oe_i,
			in_ready_i, stall_req_i, setup_flag_clr_i, irq_enable_i} = 14'h2000;
		{dplus_pullup_on_i, fifo_ready_i, ctrl_ep_i} = 5'h18;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(negedge sys_clk_i);
		check({2'h0, periph_id_o}, 8'h23);
		check({rx_ready_o, hs_valid_o, setup_received_flag_o, irq_o, 1'b0, ctrl_stage_o},
			{5'h10, ST_IDLE});
		repeat (5) @(negedge sys_clk_i);
		rst_i = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			{system_io_pin_select_i, transceiver_disable_i, dplus_pullup_on_i, usb_tx_plus_i,
				usb_tx_minus_i, usb_tx_oe_i, gpio_plus_out_i, gpio_oe_i} = rows[i][15:8];
			gpio_minus_out_i = ~gpio_plus_out_i;
			repeat (6) @(negedge sys_clk_i);
			check(pins_seen, rows[i][7:0]);
		end
		$display("pin table test done");
		bclk_run = 1'b1;
		repeat (30) @(negedge sys_clk_i);
		check(8'(bus_clk_ok_o), 8'h01);
		bclk_run = 1'b0;
		repeat (30) @(negedge sys_clk_i);
		check(8'(bus_clk_ok_o), 8'h00);
		$display("bus clock test done");
		// No-data control; flag and irq held
		irq_enable_i = 1'b1;
		setup_xfer(64'h0, ST_STATUS_IN);
		check(8'({setup_received_flag_o, irq_o}), 8'h03);
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, ZLP1);
		stage_is(ST_IDLE);
		irq_enable_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		check(8'({setup_received_flag_o, irq_o}), 8'h02);
		clr_flag();
		irq_enable_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check(8'({setup_received_flag_o, irq_o}), 8'h00);
		$display("no-data control test done");
		// Control read with zero-length status out
		setup_xfer(64'h0001_0000_0000_0080, ST_DATA_IN);
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, NAKED);
		in_ready_i = 1'b1;
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, D1);
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, D0);
		tok(TOK_OUT, 3'h0, 1'b0, 1'b1, 8'h00);
		stage_is(ST_STATUS_OUT);
		tok(TOK_OUT, 3'h0, 1'b0, 1'b1, ACKED);
		stage_is(ST_IDLE);
		$display("control read test done");
		// Control write, held off by the setup flag
		setup_xfer(64'h0002_0000_0000_0000, ST_DATA_OUT);
		tok(TOK_OUT, 3'h0, 1'b0, 1'b0, NAKED);
		clr_flag();
		tok(TOK_OUT, 3'h0, 1'b0, 1'b0, ACKED);
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, ZLP1);
		stage_is(ST_IDLE);
		$display("control write test done");
		// Abort in the data stage
		setup_xfer(64'h0001_0000_0000_0080, ST_DATA_IN);
		stall_req_i = 1'b1;
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, STALLED);
		stall_req_i = 1'b0;
		stage_is(ST_IDLE);
		$display("stall test done");
		// Control only on single-bank endpoints
		for (int i = 1; i < 8; i++) begin
			ctrl_ep_i = 3'(i);
			tok(TOK_SETUP, 3'(i), 1'b0, 1'b0, (i == 3) ? ACKED : STALLED);
		end
		ctrl_ep_i = 3'h0;
		tok(TOK_OUT, 3'h0, 1'b1, 1'b0, ISOERR);
		tok(TOK_IN, 3'h1, 1'b1, 1'b0, 8'h00);
		$display("bank test done");
		// Receiver stall loses no byte
		clr_flag();
		tok(TOK_SETUP, 3'h0, 1'b0, 1'b0, ACKED);
		rxq.delete();
		fifo_ready_i = 1'b0;
		fork
			host.send_setup(BUFPKT, ok);
			begin
				repeat (8) @(negedge sys_clk_i);
				check(8'({rx_ready_o, fifo_valid_o}), 8'h01);
				fifo_ready_i = 1'b1;
			end
		join
		check(8'(ok), 8'h01);
		repeat (4) @(negedge sys_clk_i);
		check(8'(rxq.size()), 8'h08);
		for (int i = 0; i < 8; i++) check(rxq[i], BUFPKT[8*i +: 8]);
		stage_is(ST_STATUS_IN);
		tok(TOK_IN, 3'h0, 1'b0, 1'b0, ZLP1);
		$display("buffer stall test done");
		complete_run();
	end
endmodule : usbfs_port_ctrl_bench
